// ---- logic/vdam_consts.vh ----
// Constants for the valve diagnostic alarm monitor.
// Assumes a 10 MHz clock and 32-bit Avalon-MM register access.
`ifndef VDAM_CONSTS_VH
`define VDAM_CONSTS_VH

// Timing
`define VDAM_CLK_NS 100
`define VDAM_TICK_US 1000
`define VDAM_TICK_CYC ((`VDAM_TICK_US * 1000) / `VDAM_CLK_NS)

// Register byte offsets
`define VDAM_REG_CTRL 8'h00
`define VDAM_REG_DEV_THR 8'h04
`define VDAM_REG_WAIT 8'h08
`define VDAM_REG_TEMP_LIM 8'h0C
`define VDAM_REG_ZERO_THR 8'h10
`define VDAM_REG_ZWAIT_SSC 8'h14
`define VDAM_REG_SPD_THR 8'h18
`define VDAM_REG_CLOSE_THR 8'h1C
`define VDAM_REG_TRAVEL_THR 8'h20
`define VDAM_REG_CYCLE_THR 8'h24
`define VDAM_REG_SS_XY_THR 8'h28
`define VDAM_REG_CRIT_STAT 8'h2C
`define VDAM_REG_MINOR_STAT 8'h30
`define VDAM_REG_VALVE_STAT 8'h34
`define VDAM_REG_SS_COUNT 8'h38

// Control register fields
`define VDAM_CTRL_FAILSAFE_BIT 12
`define VDAM_CTRL_SS_CLR_BIT 13

// Valve alarm bit positions
`define VDAM_AL_STICK 0
`define VDAM_AL_TRAVEL 1
`define VDAM_AL_CYCLE 2
`define VDAM_AL_ZERO_UP 3
`define VDAM_AL_ZERO_DN 4
`define VDAM_AL_CLOSE 5
`define VDAM_AL_SPD_UP 6
`define VDAM_AL_SPD_DN 7
`define VDAM_AL_DEV_POS 8
`define VDAM_AL_DEV_NEG 9
`define VDAM_AL_TEMP_HI 10
`define VDAM_AL_TEMP_LO 11

// Reset values
`define VDAM_RST_CTRL 32'h00000FFF
`define VDAM_RST_ZERO32 32'h00000000
`define VDAM_RST_TEMP_LIM 32'hFE3E0352

// Fixed limits: current in uA, temperature in 0.1 degC
`define VDAM_LOW_INPUT_CURRENT_UA 16'h0ED8
`define VDAM_OT_LOW_DC 16'hFE3E
`define VDAM_OT_HIGH_DC 16'h0352

// Fail-safe drive levels
`define VDAM_DRIVE_LOW 16'h0000
`define VDAM_DRIVE_HIGH 16'hFFFF
`endif

// ---- logic/vdam_persist.v ----
// Persistence timer: output rises once a condition has held for a wait.
// Assumes a one-cycle millisecond tick from the same clock.
`timescale 1ns/1ps
module vdam_persist (
  clk,
  rst,
  tick,
  cond,
  wait_ms,
  hold
);
  input wire clk;
  input wire rst;
  input wire tick;
  input wire cond;
  input wire [15:0] wait_ms;
  output reg hold;

  // One bit wider than the wait so every wait value can be exceeded
  reg [16:0] cnt_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 17'h00000;
      hold <= 1'b0;
    end else if (!cond) begin
      // Any break in the condition restarts the wait
      cnt_q <= 17'h00000;
      hold <= 1'b0;
    end else begin
      if (tick && cnt_q != 17'h1FFFF)
        cnt_q <= cnt_q + 17'h00001;
      // First tick may fall at once; one extra tick keeps the full wait
      hold <= (cnt_q > {1'b0, wait_ms});
    end
  end
endmodule

// ---- logic/vdam_top.v ----
// Valve diagnostic alarm monitor: thresholds, alarms, status words.
// Assumes measurement inputs come from logic on the same clock.
//
// Behaviour
// - Deviation alarm only after waiting time persists
// - Each alarm gated by its own enable
// - Temperature alarm beyond limits after wait
// - Separate high and low temperature flags
// - Deviation flag sign from travel minus input
// - Angle sensor, working, program memory faults
// - Low input current at or below limit
// - Over-temperature outside fixed lower/upper bounds
// - Minor flags for switch, drive, forcing, dummy
// - Separate up/down daily speed alarms
// - Zero-travel error alarm by drift direction
// - Closure count alarm at threshold
// - Total travel alarm at threshold
// - Reversal cycle alarm at threshold
// - Stick-slip alarm on adhesion-release movement
// - Each valve alarm readable as on/off
// - Count on XY ratio; alarm at count
// - Critical fault forces outputs to fail-safe
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "vdam_consts.vh"
module vdam_top #(
  parameter TICK_CYCLES = `VDAM_TICK_CYC
) (
  input wire clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [15:0] travel_pct,
  input wire [15:0] input_pct,
  input wire [15:0] temp_dc,
  input wire [15:0] input_current_ua,
  input wire [15:0] speed_up_max,
  input wire [15:0] speed_dn_max,
  input wire [15:0] zero_angle_now,
  input wire [15:0] zero_angle_init,
  input wire [31:0] closure_count,
  input wire [31:0] travel_total,
  input wire [31:0] cycle_count,
  input wire [15:0] stick_x,
  input wire [15:0] stick_y,
  input wire stick_sample,
  input wire angle_sensor_fault,
  input wire ram_fault,
  input wire rom_fault,
  input wire external_adjust_in_use,
  input wire drive_signal_out_of_range,
  input wire forced_end_position,
  input wire dummy_input_active,
  input wire dummy_drive_active,
  input wire settings_initialised,
  input wire [15:0] drive_in,
  input wire [15:0] travel_tx_in,
  output reg [15:0] pneumatic_drive_module,
  output reg [15:0] travel_tx_out,
  output reg critical_fail
);

  reg [31:0] ctrl_q;
  reg [31:0] dev_thr_q;
  reg [31:0] wait_q;
  reg [31:0] temp_lim_q;
  reg [31:0] zero_thr_q;
  reg [31:0] zwait_ssc_q;
  reg [31:0] spd_thr_q;
  reg [31:0] close_thr_q;
  reg [31:0] travel_thr_q;
  reg [31:0] cycle_thr_q;
  reg [31:0] ss_xy_thr_q;
  reg [2:0] crit_q;
  reg [7:0] minor_q;
  reg [11:0] valve_q;
  reg [15:0] ss_count_q;
  reg [13:0] tick_cnt_q;
  reg tick_q;
  reg [31:0] rdata_d;

  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ~avs_waitrequest;
  wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Millisecond tick; long count kept as a parameter for short sims
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 14'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[13:0] - 14'h0001) begin
      tick_cnt_q <= 14'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 14'h0001;
      tick_q <= 1'b0;
    end
  end

  // Bus: answer one cycle after request, write lands on the answer edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= rdata_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `VDAM_RST_CTRL;
      dev_thr_q <= `VDAM_RST_ZERO32;
      wait_q <= `VDAM_RST_ZERO32;
      temp_lim_q <= `VDAM_RST_TEMP_LIM;
      zero_thr_q <= `VDAM_RST_ZERO32;
      zwait_ssc_q <= `VDAM_RST_ZERO32;
      spd_thr_q <= `VDAM_RST_ZERO32;
      close_thr_q <= `VDAM_RST_ZERO32;
      travel_thr_q <= `VDAM_RST_ZERO32;
      cycle_thr_q <= `VDAM_RST_ZERO32;
      ss_xy_thr_q <= `VDAM_RST_ZERO32;
    end else begin
      // Clear command bit lives one cycle only
      ctrl_q[`VDAM_CTRL_SS_CLR_BIT] <= 1'b0;
      if (wr_go) begin
        case (avs_address)
          `VDAM_REG_CTRL: ctrl_q <= merge(ctrl_q, avs_writedata, bmask) & 32'h00003FFF;
          `VDAM_REG_DEV_THR: dev_thr_q <= merge(dev_thr_q, avs_writedata, bmask);
          `VDAM_REG_WAIT: wait_q <= merge(wait_q, avs_writedata, bmask);
          `VDAM_REG_TEMP_LIM: temp_lim_q <= merge(temp_lim_q, avs_writedata, bmask);
          `VDAM_REG_ZERO_THR: zero_thr_q <= merge(zero_thr_q, avs_writedata, bmask);
          `VDAM_REG_ZWAIT_SSC: zwait_ssc_q <= merge(zwait_ssc_q, avs_writedata, bmask);
          `VDAM_REG_SPD_THR: spd_thr_q <= merge(spd_thr_q, avs_writedata, bmask);
          `VDAM_REG_CLOSE_THR: close_thr_q <= merge(close_thr_q, avs_writedata, bmask);
          `VDAM_REG_TRAVEL_THR: travel_thr_q <= merge(travel_thr_q, avs_writedata, bmask);
          `VDAM_REG_CYCLE_THR: cycle_thr_q <= merge(cycle_thr_q, avs_writedata, bmask);
          `VDAM_REG_SS_XY_THR: ss_xy_thr_q <= merge(ss_xy_thr_q, avs_writedata, bmask);
          default: ;
        endcase
      end
    end
  end

  always @* begin
    case (avs_address)
      `VDAM_REG_CTRL: rdata_d = ctrl_q;
      `VDAM_REG_DEV_THR: rdata_d = dev_thr_q;
      `VDAM_REG_WAIT: rdata_d = wait_q;
      `VDAM_REG_TEMP_LIM: rdata_d = temp_lim_q;
      `VDAM_REG_ZERO_THR: rdata_d = zero_thr_q;
      `VDAM_REG_ZWAIT_SSC: rdata_d = zwait_ssc_q;
      `VDAM_REG_SPD_THR: rdata_d = spd_thr_q;
      `VDAM_REG_CLOSE_THR: rdata_d = close_thr_q;
      `VDAM_REG_TRAVEL_THR: rdata_d = travel_thr_q;
      `VDAM_REG_CYCLE_THR: rdata_d = cycle_thr_q;
      `VDAM_REG_SS_XY_THR: rdata_d = ss_xy_thr_q;
      `VDAM_REG_CRIT_STAT: rdata_d = {29'h0000000, crit_q};
      `VDAM_REG_MINOR_STAT: rdata_d = {24'h000000, minor_q};
      `VDAM_REG_VALVE_STAT: rdata_d = {20'h00000, valve_q};
      `VDAM_REG_SS_COUNT: rdata_d = {16'h0000, ss_count_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  wire signed [16:0] dev = $signed({travel_pct[15], travel_pct})
                         - $signed({input_pct[15], input_pct});
  wire signed [16:0] dev_pos_lim = $signed({1'b0, dev_thr_q[15:0]});
  wire signed [16:0] dev_neg_lim = -$signed({1'b0, dev_thr_q[31:16]});
  wire dev_pos_raw = dev > dev_pos_lim;
  wire dev_neg_raw = dev < dev_neg_lim;

  wire temp_hi_raw = $signed(temp_dc) > $signed(temp_lim_q[15:0]);
  wire temp_lo_raw = $signed(temp_dc) < $signed(temp_lim_q[31:16]);

  wire signed [16:0] zdrift = $signed({1'b0, zero_angle_now})
                            - $signed({1'b0, zero_angle_init});
  wire zero_up_raw = zdrift >= $signed({1'b0, zero_thr_q[15:0]});
  wire zero_dn_raw = zdrift <= -$signed({1'b0, zero_thr_q[31:16]});

  wire dev_pos_hold;
  wire dev_neg_hold;
  wire temp_hi_hold;
  wire temp_lo_hold;
  wire zero_up_hold;
  wire zero_dn_hold;

  vdam_persist u_dev_pos (
    .clk(clk), .rst(rst), .tick(tick_q), .cond(dev_pos_raw),
    .wait_ms(wait_q[15:0]), .hold(dev_pos_hold)
  );
  vdam_persist u_dev_neg (
    .clk(clk), .rst(rst), .tick(tick_q), .cond(dev_neg_raw),
    .wait_ms(wait_q[15:0]), .hold(dev_neg_hold)
  );
  vdam_persist u_temp_hi (
    .clk(clk), .rst(rst), .tick(tick_q), .cond(temp_hi_raw),
    .wait_ms(wait_q[31:16]), .hold(temp_hi_hold)
  );
  vdam_persist u_temp_lo (
    .clk(clk), .rst(rst), .tick(tick_q), .cond(temp_lo_raw),
    .wait_ms(wait_q[31:16]), .hold(temp_lo_hold)
  );
  vdam_persist u_zero_up (
    .clk(clk), .rst(rst), .tick(tick_q), .cond(zero_up_raw),
    .wait_ms(zwait_ssc_q[15:0]), .hold(zero_up_hold)
  );
  vdam_persist u_zero_dn (
    .clk(clk), .rst(rst), .tick(tick_q), .cond(zero_dn_raw),
    .wait_ms(zwait_ssc_q[15:0]), .hold(zero_dn_hold)
  );

  // Ratio Y/X at threshold, 8.8 fixed point
  wire [31:0] ss_lhs = {stick_y, 8'h00, 8'h00} >> 8;
  wire [31:0] ss_rhs = stick_x * ss_xy_thr_q[15:0];
  wire ss_hit = stick_sample & (stick_x != 16'h0000) & (ss_lhs >= ss_rhs);
  wire ss_clr = ctrl_q[`VDAM_CTRL_SS_CLR_BIT];

  always @(posedge clk or posedge rst) begin
    if (rst)
      ss_count_q <= 16'h0000;
    else if (ss_clr)
      // A hit in the clear cycle still counts
      ss_count_q <= {15'h0000, ss_hit};
    else if (ss_hit && ss_count_q != 16'hFFFF)
      ss_count_q <= ss_count_q + 16'h0001;
  end

  reg [11:0] raw_al;
  always @* begin
    raw_al = 12'h000;
    raw_al[`VDAM_AL_STICK] = (ss_count_q >= zwait_ssc_q[31:16]);
    raw_al[`VDAM_AL_TRAVEL] = (travel_total >= travel_thr_q);
    raw_al[`VDAM_AL_CYCLE] = (cycle_count >= cycle_thr_q);
    raw_al[`VDAM_AL_ZERO_UP] = zero_up_hold;
    raw_al[`VDAM_AL_ZERO_DN] = zero_dn_hold;
    raw_al[`VDAM_AL_CLOSE] = (closure_count >= close_thr_q);
    raw_al[`VDAM_AL_SPD_UP] = (speed_up_max > spd_thr_q[15:0]);
    raw_al[`VDAM_AL_SPD_DN] = (speed_dn_max > spd_thr_q[31:16]);
    raw_al[`VDAM_AL_DEV_POS] = dev_pos_hold;
    raw_al[`VDAM_AL_DEV_NEG] = dev_neg_hold;
    raw_al[`VDAM_AL_TEMP_HI] = temp_hi_hold;
    raw_al[`VDAM_AL_TEMP_LO] = temp_lo_hold;
  end

  wire any_crit = angle_sensor_fault | ram_fault | rom_fault;
  wire fs_high = ctrl_q[`VDAM_CTRL_FAILSAFE_BIT];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      valve_q <= 12'h000;
      crit_q <= 3'h0;
      minor_q <= 8'h00;
      critical_fail <= 1'b0;
      pneumatic_drive_module <= `VDAM_DRIVE_LOW;
      travel_tx_out <= `VDAM_DRIVE_LOW;
    end else begin
      valve_q <= raw_al & ctrl_q[11:0];
      crit_q <= {rom_fault, ram_fault, angle_sensor_fault};
      // Input current at or below limit
      minor_q[0] <= (input_current_ua <= `VDAM_LOW_INPUT_CURRENT_UA);
      minor_q[1] <= ($signed(temp_dc) < $signed(`VDAM_OT_LOW_DC))
                  | ($signed(temp_dc) > $signed(`VDAM_OT_HIGH_DC));
      minor_q[2] <= external_adjust_in_use;
      minor_q[3] <= drive_signal_out_of_range;
      minor_q[4] <= forced_end_position;
      minor_q[5] <= dummy_input_active;
      minor_q[6] <= dummy_drive_active;
      minor_q[7] <= settings_initialised;
      critical_fail <= any_crit;
      if (any_crit) begin
        pneumatic_drive_module <= fs_high ? `VDAM_DRIVE_HIGH : `VDAM_DRIVE_LOW;
        travel_tx_out <= fs_high ? `VDAM_DRIVE_HIGH : `VDAM_DRIVE_LOW;
      end else begin
        pneumatic_drive_module <= drive_in;
        travel_tx_out <= travel_tx_in;
      end
    end
  end
endmodule

// ---- dv/vdam_top_asserts.sv ----
// Port-level checks for the valve alarm monitor.
// Assumes one clock domain; bound into every top instance.
`timescale 1ns/1ps
module vdam_checker (
  input wire clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire angle_sensor_fault,
  input wire ram_fault,
  input wire rom_fault,
  input wire [15:0] drive_in,
  input wire [15:0] travel_tx_in,
  input wire [15:0] pneumatic_drive_module,
  input wire [15:0] travel_tx_out,
  input wire critical_fail
);
  wire any_fault = angle_sensor_fault | ram_fault | rom_fault;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a request");
  chk_wait_short: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low too long");
  chk_idle_wait: assert property (
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low while idle");
  chk_crit_follow: assert property (
    1'b1 |=> critical_fail == $past(any_fault))
    else $error("critical flag does not follow faults");
  chk_safe_drive: assert property (
    any_fault |=> pneumatic_drive_module == 16'h0000 || pneumatic_drive_module == 16'hFFFF)
    else $error("drive not at a safe level during fault");
  chk_drive_pass: assert property (
    !any_fault |=> pneumatic_drive_module == $past(drive_in))
    else $error("drive not passed through");
  chk_tx_normal: assert property (
    !any_fault |=> travel_tx_out == $past(travel_tx_in))
    else $error("travel output not passed through");
  chk_tx_safe: assert property (
    any_fault |=> travel_tx_out == pneumatic_drive_module)
    else $error("travel output not at safe level");
  chk_unmapped_zero: assert property (
    avs_read && avs_waitrequest && avs_address == 8'h3C |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind vdam_top vdam_checker u_vdam_checker (.*);

// ---- dv/vdam_host.sv ----
// Host software model: issues register transfers to the monitor.
// Assumes an Avalon-MM slave with waitrequest on the same clock.
`timescale 1ns/1ps
module vdam_host (
  input wire clk,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
  // Leading edge keeps a back-to-back call off the release time step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// ---- dv/test_valve_diag_alarm_monitor.sv ----
// Self-checking bench for the valve alarm monitor.
// Assumes the host model owns the register bus; tick is shortened.
`timescale 1ns/1ps
`include "vdam_consts.vh"
module test_valve_diag_alarm_monitor;
  typedef struct packed {logic [31:0] cl, tr, cy; logic [15:0] up, dn, ua, tp, tv, ip, zn, ev;
    logic [7:0] em;} vdam_row_t;
  logic clk = 0, rst = 1, avs_read, avs_write, avs_waitrequest, stick_sample = 0, critical_fail;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, closure_count = 0, travel_total = 0, cycle_count = 0;
  logic [15:0] travel_pct = 0, input_pct = 0, temp_dc = 0, input_current_ua = 16'h0ED9;
  logic [15:0] speed_up_max = 0, speed_dn_max = 0, zero_angle_now = 0, zero_angle_init = 100;
  logic [15:0] stick_x = 0, stick_y = 0, drive_in = 16'h1234, travel_tx_in = 16'h5678;
  logic [15:0] pneumatic_drive_module, travel_tx_out;
  logic [2:0] fv = 0;
  logic [5:0] mv = 0;
  wire angle_sensor_fault, ram_fault, rom_fault, external_adjust_in_use;
  wire drive_signal_out_of_range, forced_end_position, dummy_input_active;
  wire dummy_drive_active, settings_initialised;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  vdam_row_t rows[8];
  assign {rom_fault, ram_fault, angle_sensor_fault} = fv;
  assign {settings_initialised, dummy_drive_active, dummy_input_active, forced_end_position,
    drive_signal_out_of_range, external_adjust_in_use} = mv;
  vdam_top #(.TICK_CYCLES(4)) u_vdam_top (.*);
  vdam_host u_vdam_host (.*);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    u_vdam_host.xfer(1'b1, a, d, be, q);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_vdam_host.xfer(1'b0, a, 32'h0, 4'hF, q);
    chk(n, q, exp);
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ap(input vdam_row_t r);
    @(posedge clk);
    closure_count <= r.cl;
    travel_total <= r.tr;
    cycle_count <= r.cy;
    speed_up_max <= r.up;
    speed_dn_max <= r.dn;
    input_current_ua <= r.ua;
    temp_dc <= r.tp;
    travel_pct <= r.tv;
    input_pct <= r.ip;
    zero_angle_now <= r.zn;
  endtask
  task automatic pulse(input logic [15:0] y);
    @(posedge clk);
    stick_y <= y;
    stick_sample <= 1'b1;
    @(posedge clk);
    stick_sample <= 1'b0;
  endtask
  initial begin
    rows = '{'{99, 199, 49, 30, 40, 3801, 250, 0, 0, 100, 0, 0},
      '{100, 200, 50, 31, 41, 3800, 851, 0, 0, 100, 16'h04E6, 8'h03},
      '{99, 199, 49, 30, 40, 0, 16'hFE3D, 0, 0, 100, 16'h0800, 8'h03},
      '{99, 199, 49, 30, 40, 3801, 850, 0, 0, 100, 0, 0},
      '{99, 199, 49, 30, 40, 3801, 16'hFE3E, 0, 0, 100, 0, 0},
      '{99, 199, 49, 30, 40, 3801, 250, 21, 10, 110, 16'h0108, 0},
      '{99, 199, 49, 30, 40, 3801, 250, 10, 21, 90, 16'h0210, 0},
      '{99, 199, 49, 30, 40, 3801, 250, 20, 10, 109, 0, 0}};
    nap(20);
    rst <= 1'b0;
    rd("ctrl_rst", `VDAM_REG_CTRL, `VDAM_RST_CTRL);
    rd("temp_lim_rst", `VDAM_REG_TEMP_LIM, `VDAM_RST_TEMP_LIM);
    wr(8'h3C, 32'hFFFFFFFF);
    rd("unmapped", 8'h3C, 32'h0);
    wr(`VDAM_REG_DEV_THR, {16'd10, 16'd10});
    wr(`VDAM_REG_ZERO_THR, {16'd10, 16'd10});
    wr(`VDAM_REG_ZWAIT_SSC, {16'd2, 16'd0});
    wr(`VDAM_REG_SPD_THR, {16'd40, 16'd30});
    wr(`VDAM_REG_CLOSE_THR, 32'd100);
    wr(`VDAM_REG_TRAVEL_THR, 32'd200);
    wr(`VDAM_REG_CYCLE_THR, 32'd50);
    wr(`VDAM_REG_SS_XY_THR, 32'h100);
    ap(rows[0]);
    wr(`VDAM_REG_VALVE_STAT, 32'hFFF);
    rd("valve_ro", `VDAM_REG_VALVE_STAT, 32'h0);
    foreach (rows[i]) begin
      ap(rows[i]);
      nap(8);
      rd("valve_row", `VDAM_REG_VALVE_STAT, rows[i].ev);
      rd("minor_row", `VDAM_REG_MINOR_STAT, rows[i].em);
    end
    wr(`VDAM_REG_CTRL, 32'h0);
    ap(rows[1]);
    nap(8);
    rd("valve_off", `VDAM_REG_VALVE_STAT, 32'h0);
    wr(`VDAM_REG_CTRL, `VDAM_RST_CTRL);
    ap(rows[0]);
    wr(`VDAM_REG_WAIT, 32'd5);
    ap(rows[5]);
    nap(8);
    rd("dev_early", `VDAM_REG_VALVE_STAT, 32'h008);
    nap(40);
    rd("dev_late", `VDAM_REG_VALVE_STAT, 32'h108);
    ap(rows[0]);
    for (int i = 0; i < 3; i++) begin
      fv <= 3'b001 << i;
      nap(3);
      chk("crit_fail", critical_fail, 1'b1);
      chk("drive_safe", pneumatic_drive_module, `VDAM_DRIVE_LOW);
      chk("tx_safe", travel_tx_out, `VDAM_DRIVE_LOW);
      rd("crit", `VDAM_REG_CRIT_STAT, 32'h1 << i);
      fv <= 3'b000;
      nap(3);
      chk("drive_norm", pneumatic_drive_module, 16'h1234);
    end
    wr(`VDAM_REG_CTRL, 32'h1FFF);
    fv <= 3'b100;
    nap(3);
    chk("drive_high", pneumatic_drive_module, `VDAM_DRIVE_HIGH);
    fv <= 3'b000;
    for (int i = 0; i < 6; i++) begin
      mv <= 6'b1 << i;
      nap(3);
      chk("tx_minor", travel_tx_out, 16'h5678);
      rd("minor", `VDAM_REG_MINOR_STAT, 32'h4 << i);
    end
    mv <= 6'b0;
    stick_x <= 16'd10;
    for (int i = 1; i < 3; i++) begin
      pulse(16'd10);
      nap(3);
      rd("ss_cnt", `VDAM_REG_SS_COUNT, i);
      rd("ss_alarm", `VDAM_REG_VALVE_STAT, i / 2);
    end
    pulse(16'd9);
    nap(3);
    rd("ss_below", `VDAM_REG_SS_COUNT, 32'd2);
    wr(`VDAM_REG_CTRL, 32'h2FFF);
    rd("ss_clr", `VDAM_REG_SS_COUNT, 32'd0);
    rd("ss_off", `VDAM_REG_VALVE_STAT, 32'h0);
    wr(`VDAM_REG_CLOSE_THR, 32'hFFFFFFFF, 4'h2);
    rd("close_be", `VDAM_REG_CLOSE_THR, 32'h0000FF64);
    // Mid-run reset with a fault present: reset must win
    fv <= 3'b001;
    rst <= 1'b1;
    nap(2);
    chk("rst_crit", critical_fail, 1'b0);
    chk("rst_wait", avs_waitrequest, 1'b1);
    chk("rst_drive", pneumatic_drive_module, `VDAM_DRIVE_LOW);
    fv <= 3'b000;
    rst <= 1'b0;
    rd("ctrl_rst2", `VDAM_REG_CTRL, `VDAM_RST_CTRL);
    rd("ssc_rst", `VDAM_REG_ZWAIT_SSC, 32'h0);
    print_verdict();
  end
endmodule
